// *** hdl/algebraic_shift_right_unit.sv ***
/*
 * Algebraic shift right unit: doubleword shift by immediate and two 32-bit
 * rotate-and-merge shifts that also load the auxiliary quotient register.
 * Assumes an APB master on sys_clk that issues the instruction word after
 * loading the operands, and a synchronous active-high reset.
 */
// What this block does
// RQ1: Doubleword immediate form shifts source right, dropping bits past position 63.
// RQ2: Doubleword form fills vacated high bits with source sign, writes destination.
// RQ3: Doubleword carry set when source negative and a one bit shifted out.
// RQ4: Zero doubleword count copies source unchanged and clears carry.
// RQ5: Doubleword carry does not depend on operating mode.
// RQ6: Doubleword form updates condition field when record bit set; carry always.
// RQ7: Narrow implementation raises illegal instruction for the doubleword form.
// RQ8: Immediate word form rotates left 32 minus N, loads aux and destination.
// RQ9: Sign word is source sign bit repeated 32 times.
// RQ10: Immediate word mask is N zeros then 32 minus N ones.
// RQ11: Word carry is OR of rotated AND inverted mask, ANDed with sign.
// RQ12: Word forms with aux register exist only in the older variant.
// RQ13: Register word form takes N from amount bits 27-31, rotates 32 minus N.
// RQ14: Register word form with amount bit 26 clear uses normal mask.
// RQ15: Register word form with amount bit 26 set uses all-zero mask.
// RQ16: Register word form writes merged word and rotated word to aux.
// RQ17: Word forms always update carry regardless of record bit.
// RQ18: Word forms update condition field only when record bit is one.
// RQ19: Merge takes rotated bits where mask is one, sign bits elsewhere.
// RQ20: Decode primary 31 with extended codes 413, 952, 920; six-bit count.
`timescale 1ns/1ps

module algebraic_shift_right_unit (
   input  wire logic                 sys_clk,
   input  wire logic                 reset,
   input  wire asru_pkg::asru_apb_req_t apbReq,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic [63:0]               destValue,
   output logic [4:0]                destIndex,
   output logic [31:0]               auxQuotient,
   output logic [31:0]               fixedExceptionReg,
   output logic [3:0]                conditionFieldZero,
   output logic                      resultStrobe,
   output logic                      illegalTrap
);

   // ==========================================================================
   // Functions.

   // Rotating left by 32 minus N equals rotating right by N.
   function automatic logic [31:0] rotRight(input logic [31:0] w, input logic [4:0] n);
      logic [63:0] dbl;
      dbl = {w, w} >> n;
      return dbl[31:0];
   endfunction

   // Condition field from a signed result and the summary overflow bit.
   function automatic logic [3:0] condFlags(input logic signed [63:0] v, input logic so);
      logic [3:0] f;
      f = '0;
      f[asru_pkg::ASRU_CR_NEG_BIT]  = v < 0;
      f[asru_pkg::ASRU_CR_POS_BIT]  = v > 0;
      f[asru_pkg::ASRU_CR_ZERO_BIT] = v == 0;
      f[asru_pkg::ASRU_CR_SO_BIT]   = so;
      return f;
   endfunction

   // ==========================================================================
   // State.
   asru_pkg::asru_regs_t regs_ff;
   asru_pkg::asru_regs_t nxt_regs;

   // ==========================================================================
   // Decode and datapath.
   logic        isPrimary;
   logic        isDword;
   logic        isWordImm;
   logic        isWordReg;
   logic        isLegal;
   logic        recordBit;
   logic [5:0]  dwCount;
   logic [63:0] dwResult;
   logic [63:0] dwLost;
   logic        dwCarry;
   logic [4:0]  wdCount;
   logic        wdZeroMask;
   logic [31:0] wdSrc;
   logic [31:0] wdSign;
   logic [31:0] wdRot;
   logic [31:0] wdMask;
   logic [31:0] wdMerged;
   logic        wdCarry;
   logic [63:0] dwCmp;

   always_comb begin
      isPrimary = regs_ff.instr[31:26] == asru_pkg::ASRU_PRIMARY_OP;                  // [RQ20]
      isDword   = isPrimary && regs_ff.instr[10:2] == asru_pkg::ASRU_XO_DW_IMM;       // [RQ20]
      isWordImm = isPrimary && regs_ff.instr[10:1] == asru_pkg::ASRU_XO_WD_IMM;       // [RQ20]
      isWordReg = isPrimary && regs_ff.instr[10:1] == asru_pkg::ASRU_XO_WD_REG;       // [RQ20]
      // Wide-only and old-variant-only forms are refused when not configured.
      isLegal   = (isDword && regs_ff.cfgWide)                                        // [RQ7]
                  || ((isWordImm || isWordReg) && regs_ff.cfgOld);                    // [RQ12]
      recordBit = regs_ff.instr[0];

      // Doubleword immediate: count high bit sits apart in the instruction.
      dwCount  = {regs_ff.instr[1], regs_ff.instr[15:11]};                            // [RQ20]
      dwResult = 64'($signed(regs_ff.src) >>> dwCount);                               // [RQ1] [RQ2]
      dwLost   = regs_ff.src & ~({64{1'b1}} << dwCount);                              // [RQ1]
      // A zero count loses nothing, so the carry clears by itself.
      dwCarry  = regs_ff.src[63] && (|dwLost);                                        // [RQ3] [RQ4] [RQ5]
      dwCmp    = regs_ff.cfgMode64 ? dwResult : {{32{dwResult[31]}}, dwResult[31:0]};

      // Word forms.
      wdCount    = isWordReg ? regs_ff.amount[4:0] : regs_ff.instr[15:11];            // [RQ13]
      wdZeroMask = isWordReg && regs_ff.amount[asru_pkg::ASRU_AMT_MASK_BIT];          // [RQ14]
      wdSrc      = regs_ff.src[31:0];
      wdSign     = {32{wdSrc[31]}};                                                   // [RQ9]
      wdRot      = rotRight(wdSrc, wdCount);                                          // [RQ8] [RQ13]
      wdMask     = wdZeroMask ? 32'h0000_0000                                         // [RQ15]
                              : (32'hFFFF_FFFF >> wdCount);                           // [RQ10] [RQ14]
      wdMerged   = (wdRot & wdMask) | (wdSign & ~wdMask);                             // [RQ19]
      wdCarry    = (|(wdRot & ~wdMask)) && wdSrc[31];                                 // [RQ11]
   end

   // ==========================================================================
   // Next-state logic: APB slave and execution.
   logic        apbAccess;
   logic        apbCommit;
   logic [31:0] readData;
   logic        readHit;
   logic [31:0] xerWord;
   logic [31:0] cfgWord;
   logic [31:0] statusWord;

   always_comb begin
      nxt_regs = regs_ff;
      nxt_regs.resultStrobe = 1'b0;
      nxt_regs.illegalTrap  = 1'b0;

      xerWord = '0;
      xerWord[asru_pkg::ASRU_XER_SO_BIT] = regs_ff.xerSo;
      xerWord[asru_pkg::ASRU_XER_CA_BIT] = regs_ff.xerCa;
      cfgWord = '0;
      cfgWord[asru_pkg::ASRU_CFG_WIDE_BIT] = regs_ff.cfgWide;
      cfgWord[asru_pkg::ASRU_CFG_OLD_BIT]  = regs_ff.cfgOld;
      cfgWord[asru_pkg::ASRU_CFG_M64_BIT]  = regs_ff.cfgMode64;
      statusWord = '0;
      statusWord[asru_pkg::ASRU_ST_BUSY_BIT] = regs_ff.state == asru_pkg::ASRU_EXEC;
      statusWord[asru_pkg::ASRU_ST_DONE_BIT] = regs_ff.done;
      statusWord[asru_pkg::ASRU_ST_ILL_BIT]  = regs_ff.illegal;

      // The slave inserts one wait state so that read data come from a flop.
      apbAccess = apbReq.psel && apbReq.penable;
      apbCommit = apbAccess && regs_ff.pready;
      nxt_regs.pready = apbAccess && !regs_ff.pready;

      readHit  = 1'b1;
      readData = '0;
      case (apbReq.paddr)
         asru_pkg::ASRU_OFS_SRC_HI: readData = regs_ff.src[63:32];
         asru_pkg::ASRU_OFS_SRC_LO: readData = regs_ff.src[31:0];
         asru_pkg::ASRU_OFS_AMOUNT: readData = regs_ff.amount;
         asru_pkg::ASRU_OFS_INSTR:  readData = regs_ff.instr;
         asru_pkg::ASRU_OFS_DST_HI: readData = regs_ff.dest[63:32];
         asru_pkg::ASRU_OFS_DST_LO: readData = regs_ff.dest[31:0];
         asru_pkg::ASRU_OFS_MQ:     readData = regs_ff.mq;
         asru_pkg::ASRU_OFS_XER:    readData = xerWord;
         asru_pkg::ASRU_OFS_CR0:    readData = {28'h000_0000, regs_ff.cr0};
         asru_pkg::ASRU_OFS_CONFIG: readData = cfgWord;
         asru_pkg::ASRU_OFS_STATUS: readData = statusWord;
         default:                   readHit  = 1'b0;
      endcase

      if (apbAccess && !regs_ff.pready) begin
         nxt_regs.prdata  = apbReq.pwrite ? 32'h0000_0000 : readData;
         nxt_regs.pslverr = !readHit;
      end else begin
         // Read data and error stand for the single answer cycle only.
         nxt_regs.prdata  = '0;
         nxt_regs.pslverr = 1'b0;
      end

      // Software writes take effect at the edge that completes the transfer.
      if (apbCommit && apbReq.pwrite) begin
         case (apbReq.paddr)
            asru_pkg::ASRU_OFS_SRC_HI: nxt_regs.src[63:32] = apbReq.pwdata;
            asru_pkg::ASRU_OFS_SRC_LO: nxt_regs.src[31:0]  = apbReq.pwdata;
            asru_pkg::ASRU_OFS_AMOUNT: nxt_regs.amount     = apbReq.pwdata;
            asru_pkg::ASRU_OFS_INSTR: begin
               nxt_regs.instr   = apbReq.pwdata;
               nxt_regs.state   = asru_pkg::ASRU_EXEC;
               nxt_regs.done    = 1'b0;
               nxt_regs.illegal = 1'b0;
            end
            asru_pkg::ASRU_OFS_DST_HI: nxt_regs.dest[63:32] = apbReq.pwdata;
            asru_pkg::ASRU_OFS_DST_LO: nxt_regs.dest[31:0]  = apbReq.pwdata;
            asru_pkg::ASRU_OFS_MQ:     nxt_regs.mq          = apbReq.pwdata;
            asru_pkg::ASRU_OFS_XER: begin
               nxt_regs.xerSo = apbReq.pwdata[asru_pkg::ASRU_XER_SO_BIT];
               nxt_regs.xerCa = apbReq.pwdata[asru_pkg::ASRU_XER_CA_BIT];
            end
            asru_pkg::ASRU_OFS_CR0:    nxt_regs.cr0 = apbReq.pwdata[3:0];
            asru_pkg::ASRU_OFS_CONFIG: begin
               nxt_regs.cfgWide   = apbReq.pwdata[asru_pkg::ASRU_CFG_WIDE_BIT];
               nxt_regs.cfgOld    = apbReq.pwdata[asru_pkg::ASRU_CFG_OLD_BIT];
               nxt_regs.cfgMode64 = apbReq.pwdata[asru_pkg::ASRU_CFG_M64_BIT];
            end
            asru_pkg::ASRU_OFS_STATUS: begin
               // Write one to clear the sticky flags.
               if (apbReq.pwdata[asru_pkg::ASRU_ST_DONE_BIT]) begin
                  nxt_regs.done = 1'b0;
               end
               if (apbReq.pwdata[asru_pkg::ASRU_ST_ILL_BIT]) begin
                  nxt_regs.illegal = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // Execution overrides a software write in the same cycle to each result that it updates.
      case (regs_ff.state)
         asru_pkg::ASRU_IDLE: begin
         end
         asru_pkg::ASRU_EXEC: begin
            nxt_regs.state = asru_pkg::ASRU_IDLE;
            nxt_regs.done  = 1'b1;
            if (!isLegal) begin
               nxt_regs.illegal     = 1'b1;                                           // [RQ7]
               nxt_regs.illegalTrap = 1'b1;                                           // [RQ7] [RQ12]
            end else if (isDword) begin
               nxt_regs.dest         = dwResult;                                      // [RQ2] [RQ4]
               nxt_regs.xerCa        = dwCarry;                                       // [RQ6]
               nxt_regs.destIndex    = regs_ff.instr[20:16];
               nxt_regs.resultStrobe = 1'b1;
               if (recordBit) begin
                  nxt_regs.cr0 = condFlags(dwCmp, regs_ff.xerSo);                     // [RQ6]
               end
            end else begin
               nxt_regs.dest         = {{32{wdMerged[31]}}, wdMerged};                // [RQ16]
               nxt_regs.mq           = wdRot;                                         // [RQ8] [RQ16]
               nxt_regs.xerCa        = wdCarry;                                       // [RQ17]
               nxt_regs.destIndex    = regs_ff.instr[20:16];
               nxt_regs.resultStrobe = 1'b1;
               if (recordBit) begin
                  nxt_regs.cr0 = condFlags({{32{wdMerged[31]}}, wdMerged},
                                           regs_ff.xerSo);                            // [RQ18]
               end
            end
         end
         default: nxt_regs.state = asru_pkg::ASRU_IDLE;
      endcase
   end

   // ==========================================================================
   // Registers.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         regs_ff           <= '0;
         regs_ff.cfgWide   <= asru_pkg::ASRU_CONFIG_RST[asru_pkg::ASRU_CFG_WIDE_BIT];
         regs_ff.cfgOld    <= asru_pkg::ASRU_CONFIG_RST[asru_pkg::ASRU_CFG_OLD_BIT];
         regs_ff.cfgMode64 <= asru_pkg::ASRU_CONFIG_RST[asru_pkg::ASRU_CFG_M64_BIT];
      end else begin
         regs_ff <= nxt_regs;
      end
   end

   // ==========================================================================
   // Outputs, each straight from a flop.
   assign prdata             = regs_ff.prdata;
   assign pready             = regs_ff.pready;
   assign pslverr            = regs_ff.pslverr;
   assign destValue          = regs_ff.dest;
   assign destIndex          = regs_ff.destIndex;
   assign auxQuotient        = regs_ff.mq;
   assign fixedExceptionReg  = {regs_ff.xerSo, 1'b0, regs_ff.xerCa, 29'h0000_0000};
   assign conditionFieldZero = regs_ff.cr0;
   assign resultStrobe       = regs_ff.resultStrobe;
   assign illegalTrap        = regs_ff.illegalTrap;

endmodule

// *** hdl/asru_pkg.sv ***
/*
 * Constants, register map and carrier types of the algebraic shift right unit.
 * Assumes a 32-bit APB master and a single 25 MHz clock domain.
 */
package asru_pkg;

   // ==========================================================================
   // Register map, byte addresses.
   localparam int unsigned ASRU_ADDR_W     = 8;
   localparam logic [7:0]  ASRU_OFS_SRC_HI = 8'h00;
   localparam logic [7:0]  ASRU_OFS_SRC_LO = 8'h04;
   localparam logic [7:0]  ASRU_OFS_AMOUNT = 8'h08;
   localparam logic [7:0]  ASRU_OFS_INSTR  = 8'h0C;
   localparam logic [7:0]  ASRU_OFS_DST_HI = 8'h10;
   localparam logic [7:0]  ASRU_OFS_DST_LO = 8'h14;
   localparam logic [7:0]  ASRU_OFS_MQ     = 8'h18;
   localparam logic [7:0]  ASRU_OFS_XER    = 8'h1C;
   localparam logic [7:0]  ASRU_OFS_CR0    = 8'h20;
   localparam logic [7:0]  ASRU_OFS_CONFIG = 8'h24;
   localparam logic [7:0]  ASRU_OFS_STATUS = 8'h28;

   // ==========================================================================
   // Field positions.
   localparam int unsigned ASRU_XER_SO_BIT   = 31;
   localparam int unsigned ASRU_XER_CA_BIT   = 29;
   localparam int unsigned ASRU_CR_NEG_BIT   = 3;
   localparam int unsigned ASRU_CR_POS_BIT   = 2;
   localparam int unsigned ASRU_CR_ZERO_BIT  = 1;
   localparam int unsigned ASRU_CR_SO_BIT    = 0;
   localparam int unsigned ASRU_CFG_WIDE_BIT = 0;
   localparam int unsigned ASRU_CFG_OLD_BIT  = 1;
   localparam int unsigned ASRU_CFG_M64_BIT  = 2;
   localparam int unsigned ASRU_ST_BUSY_BIT  = 0;
   localparam int unsigned ASRU_ST_DONE_BIT  = 1;
   localparam int unsigned ASRU_ST_ILL_BIT   = 2;
   localparam int unsigned ASRU_AMT_MASK_BIT = 5;

   // ==========================================================================
   // Instruction encodings and reset values.
   localparam logic [5:0]  ASRU_PRIMARY_OP  = 6'h1F;
   localparam logic [8:0]  ASRU_XO_DW_IMM   = 9'h19D;
   localparam logic [9:0]  ASRU_XO_WD_IMM   = 10'h3B8;
   localparam logic [9:0]  ASRU_XO_WD_REG   = 10'h398;
   localparam logic [31:0] ASRU_CONFIG_RST  = 32'h0000_0007;

   typedef enum logic [0:0] {
      ASRU_IDLE = 1'b0,
      ASRU_EXEC = 1'b1
   } asru_state_t;

   typedef struct packed {
      logic [7:0]  paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } asru_apb_req_t;

   typedef struct packed {
      asru_state_t state;
      logic [63:0] src;
      logic [31:0] amount;
      logic [31:0] instr;
      logic [63:0] dest;
      logic [31:0] mq;
      logic        xerSo;
      logic        xerCa;
      logic [3:0]  cr0;
      logic        cfgWide;
      logic        cfgOld;
      logic        cfgMode64;
      logic        done;
      logic        illegal;
      logic        resultStrobe;
      logic        illegalTrap;
      logic [4:0]  destIndex;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } asru_regs_t;

endpackage

// *** verif/asru_monitor.sv ***
/* Port checker for the algebraic shift right unit.
   Assumes one sys_clk domain, synchronous reset, bound to the top module. */
`timescale 1ns/1ps
module asru_monitor (
   input wire logic                    sys_clk,
   input wire logic                    reset,
   input wire asru_pkg::asru_apb_req_t apbReq,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic [63:0]             destValue,
   input wire logic [4:0]              destIndex,
   input wire logic [31:0]             auxQuotient,
   input wire logic [31:0]             fixedExceptionReg,
   input wire logic [3:0]              conditionFieldZero,
   input wire logic                    resultStrobe,
   input wire logic                    illegalTrap
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_ready_wait;
      apbReq.psel && apbReq.penable && !$past(apbReq.penable) |-> !pready ##1 pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready late");
   property p_err_zero;
      pslverr || !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("prdata not zero");
   property p_result_pulse;
      resultStrobe |=> !resultStrobe && !illegalTrap;
   endproperty
   a_result_pulse: assert property (p_result_pulse) else $error("strobe too long");
   property p_trap_keep;
      illegalTrap |-> $stable(destValue) && $stable(auxQuotient) && !resultStrobe;
   endproperty
   a_trap_keep: assert property (p_trap_keep) else $error("refused op changed result");
   property p_xer_bits;
      (fixedExceptionReg & 32'h5FFF_FFFF) == 32'h0000_0000;
   endproperty
   a_xer_bits: assert property (p_xer_bits) else $error("stray exception bits");
   property p_carry_neg;
      resultStrobe && fixedExceptionReg[29] |-> destValue[63];
   endproperty
   a_carry_neg: assert property (p_carry_neg) else $error("carry on positive");
   property p_cr_cause;
      !$stable(conditionFieldZero) |-> resultStrobe || $past(pready);
   endproperty
   a_cr_cause: assert property (p_cr_cause) else $error("field moved alone");
   property p_aux_cause;
      !$stable(auxQuotient) |-> resultStrobe || $past(pready);
   endproperty
   a_aux_cause: assert property (p_aux_cause) else $error("aux moved alone");
   property p_dest_cause;
      !$stable(destValue) |-> resultStrobe || $past(pready);
   endproperty
   a_dest_cause: assert property (p_dest_cause) else $error("dest moved alone");
endmodule

bind algebraic_shift_right_unit asru_monitor asru_monitor_i (
   .sys_clk(sys_clk), .reset(reset), .apbReq(apbReq), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .destValue(destValue), .destIndex(destIndex),
   .auxQuotient(auxQuotient), .fixedExceptionReg(fixedExceptionReg),
   .conditionFieldZero(conditionFieldZero), .resultStrobe(resultStrobe),
   .illegalTrap(illegalTrap));

// *** verif/asru_apb_master.sv ***
/* APB master standing in for the decoder side of the shift unit.
   Assumes the bench pulses start for one cycle per transfer while idle. */
`timescale 1ns/1ps
module asru_apb_master (
   input  wire logic               sys_clk,
   input  wire logic               reset,
   input  wire logic               start,
   input  wire logic               wr,
   input  wire logic [7:0]         addr,
   input  wire logic [31:0]        wdata,
   input  wire logic [31:0]        prdata,
   input  wire logic               pready,
   input  wire logic               pslverr,
   output asru_pkg::asru_apb_req_t apbReq,
   output logic                    done,
   output logic [32:0]             result
);
   logic [1:0] phase_ff;
   always_ff @(posedge sys_clk) begin
      done <= 1'b0;
      if (reset) begin
         apbReq <= '0;
         phase_ff <= 2'd0;
      end else if (phase_ff == 2'd0 && start) begin
         apbReq <= '{paddr: addr, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wdata};
         phase_ff <= 2'd1;
      end else if (phase_ff == 2'd1) begin
         apbReq.penable <= 1'b1;
         phase_ff <= 2'd2;
      end else if (phase_ff == 2'd2 && pready) begin
         // Released lines show inverted values so stale data cannot look valid.
         result <= {pslverr, prdata};
         done <= 1'b1;
         apbReq <= '{paddr: ~apbReq.paddr, psel: 1'b0, penable: 1'b0,
                     pwrite: ~apbReq.pwrite, pwdata: ~apbReq.pwdata};
         phase_ff <= 2'd0;
      end
   end
endmodule

// *** verif/tb_algebraic_shift_right_unit.sv ***
/* Self-checking bench of the shift unit: random operations against a model.
   Assumes the APB master model and the bound port checker. */
`timescale 1ns/1ps
module tb_algebraic_shift_right_unit;
   logic sys_clk, reset, start, wr, done, pready, pslverr, resultStrobe, illegalTrap;
   logic [7:0]  addr;
   logic [31:0] wdata, prdata, auxQuotient, fixedExceptionReg, rot, msk, m, mq, amt, ins;
   logic [32:0] result;
   logic [63:0] destValue, src, dst, cv;
   logic [4:0]  destIndex;
   logic [3:0]  conditionFieldZero, cr;
   logic [5:0]  n, cnt;
   logic        ca, rc;
   logic [32:0] expQ[$];
   logic        strQ[$];
   int          fails, n_tests, kind;
   asru_pkg::asru_apb_req_t apbReq;

   asru_apb_master asru_apb_master_i (.sys_clk(sys_clk), .reset(reset), .start(start),
      .wr(wr), .addr(addr), .wdata(wdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .apbReq(apbReq), .done(done), .result(result));
   algebraic_shift_right_unit algebraic_shift_right_unit_i (.sys_clk(sys_clk),
      .reset(reset), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .destValue(destValue), .destIndex(destIndex), .auxQuotient(auxQuotient),
      .fixedExceptionReg(fixedExceptionReg), .conditionFieldZero(conditionFieldZero),
      .resultStrobe(resultStrobe), .illegalTrap(illegalTrap));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic cmp_word(input logic [32:0] e, input logic [32:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t word exp %h got %h", $time, e, g);
      end
   endtask

   task automatic cmp_flag(input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t flag exp %h got %h", $time, e, g);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      start <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      start <= 1'b0;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (done !== 1'b1 && k < 64);
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      expQ.push_back(e);
      xfer(1'b0, a, 32'h0000_0000);
   endtask

   // Watcher: compares every finished read and every strobe with the oldest note.
   always @(posedge sys_clk) begin
      if (done === 1'b1 && wr === 1'b0) cmp_word(expQ.pop_front(), result);
      if (resultStrobe === 1'b1 || illegalTrap === 1'b1)
         cmp_flag(strQ.size() > 0 ? strQ.pop_front() : 1'bx, resultStrobe);
   end

   initial begin
      #1_000_000;
      fails++;
      complete_run();
   end

   initial begin
      {reset, start, wr, addr, wdata, fails, n_tests, mq, cr} = '1;
      {start, wr, addr, wdata, fails, n_tests, mq, cr} = '0;
      void'($urandom(8311));
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      rd(asru_pkg::ASRU_OFS_CONFIG, {1'b0, asru_pkg::ASRU_CONFIG_RST});
      rd(asru_pkg::ASRU_OFS_XER, 33'h0_0000_0000);
      for (int i = 0; i < 15; i++) begin
         kind = i % 3;
         rc = ((i / 3) % 2) == 1;
         src = {$urandom, $urandom};
         src[63] = i[0];
         src[31] = i[0];
         amt = $urandom;
         amt[5] = i[2];
         cnt = (i < 3) ? 6'h00 : 6'($urandom);
         if (i == 4) {src[31:0], cnt} = {32'h9000_3000, 6'h04};
         if (kind == 0) begin
            n = cnt;
            dst = $signed(src) >>> n;
            ca = src[63] & (|(src & ~(64'hFFFF_FFFF_FFFF_FFFF << n)));
            cv = (i < 9) ? dst : {{32{dst[31]}}, dst[31:0]};
         end else begin
            n = (kind == 1) ? {1'b0, cnt[4:0]} : {1'b0, amt[4:0]};
            rot = (src[31:0] >> n) | (src[31:0] << (32 - n));
            msk = (kind == 2 && amt[5]) ? 32'h0000_0000 : 32'hFFFF_FFFF >> n;
            m = (rot & msk) | ({32{src[31]}} & ~msk);
            ca = src[31] & (|(rot & ~msk));
            dst = {{32{m[31]}}, m};
            mq = rot;
            cv = dst;
         end
         if (rc) cr = {cv[63], !cv[63] && cv != 64'h0, cv == 64'h0, 1'b0};
         ins = {asru_pkg::ASRU_PRIMARY_OP, 5'h00, 5'(i), cnt[4:0], 11'h000};
         ins[10:0] = (kind == 0) ? {asru_pkg::ASRU_XO_DW_IMM, cnt[5], rc} :
            {(kind == 1) ? asru_pkg::ASRU_XO_WD_IMM : asru_pkg::ASRU_XO_WD_REG, rc};
         // Operations from nine on run in 32-bit mode.
         xfer(1'b1, asru_pkg::ASRU_OFS_CONFIG, (i < 9) ? 32'h7 : 32'h3);
         xfer(1'b1, asru_pkg::ASRU_OFS_SRC_HI, src[63:32]);
         xfer(1'b1, asru_pkg::ASRU_OFS_SRC_LO, src[31:0]);
         xfer(1'b1, asru_pkg::ASRU_OFS_AMOUNT, amt);
         strQ.push_back(1'b1);
         xfer(1'b1, asru_pkg::ASRU_OFS_INSTR, ins);
         rd(asru_pkg::ASRU_OFS_DST_HI, {1'b0, dst[63:32]});
         rd(asru_pkg::ASRU_OFS_DST_LO, {1'b0, dst[31:0]});
         rd(asru_pkg::ASRU_OFS_MQ, {1'b0, mq});
         rd(asru_pkg::ASRU_OFS_XER, {3'b000, ca, 29'h0});
         rd(asru_pkg::ASRU_OFS_CR0, {29'h0, cr});
         $display("test %0d done", i);
      end
      xfer(1'b1, asru_pkg::ASRU_OFS_CONFIG, 32'h0);
      strQ.push_back(1'b0);
      xfer(1'b1, asru_pkg::ASRU_OFS_INSTR, 32'h7C00_0674);
      strQ.push_back(1'b0);
      xfer(1'b1, asru_pkg::ASRU_OFS_INSTR, 32'h7C00_0770);
      xfer(1'b1, asru_pkg::ASRU_OFS_CONFIG, 32'h7);
      strQ.push_back(1'b0);
      xfer(1'b1, asru_pkg::ASRU_OFS_INSTR, 32'h7C00_0000);
      rd(asru_pkg::ASRU_OFS_DST_LO, {1'b0, dst[31:0]});
      rd(asru_pkg::ASRU_OFS_MQ, {1'b0, mq});
      rd(asru_pkg::ASRU_OFS_STATUS, 33'h0_0000_0006);
      rd(8'h3C, 33'h1_0000_0000);
      $display("test refusals done");
      repeat (4) @(posedge sys_clk);
      cmp_word(33'h0, 33'(expQ.size() + strQ.size()));
      complete_run();
   end
endmodule
